// ===== verilog/dprs_defines.svh
// Constants for the debug port register select block: target addresses,
// link command codes, field positions and reset values.
// Assumes it is included by bare name from the package and the top module.
`ifndef DPRS_DEFINES_SVH
`define DPRS_DEFINES_SVH

// Target register addresses held in target_register_select
`define DPRS_ADDR_DEVICE_ID   8'h00
`define DPRS_ADDR_REVISION_ID 8'h01
`define DPRS_ADDR_FLASH_CTL   8'h02
`define DPRS_ADDR_FLASH_DAT   8'hb4

// Link command codes, sent least significant bit first
`define DPRS_CMD_ADDR_WR      2'h0
`define DPRS_CMD_ADDR_RD      2'h1
`define DPRS_CMD_DATA_WR      2'h2
`define DPRS_CMD_DATA_RD      2'h3
`define DPRS_CMD_RD_BIT       0

// Bit counts inside a frame
`define DPRS_CMD_LAST         3'h1
`define DPRS_BYTE_LAST        3'h7

// Reset values
`define DPRS_SEL_RESET        8'h00
`define DPRS_FLASH_CTL_RESET  8'h00
`define DPRS_FLASH_DAT_RESET  8'h00
`define DPRS_RDATA_RESET      8'h00
`define DPRS_UNLISTED_READ    8'h00

`endif

// ===== verilog/dprs_pkg.sv
// Types shared by the debug port register select block.
// Assumes the defines header is on the include path.
package dprs_pkg;
  `include "dprs_defines.svh"

  // Link state machine, Gray coded along idle-cmd-data-wait-ready-send
  typedef enum logic [2:0] {
    DPRS_LS_IDLE  = 3'h0,
    DPRS_LS_CMD   = 3'h1,
    DPRS_LS_DATA  = 3'h3,
    DPRS_LS_WAIT  = 3'h2,
    DPRS_LS_READY = 3'h6,
    DPRS_LS_SEND  = 3'h7
  } dprs_link_state_t;

  typedef logic [1:0] dprs_cmd_t;
  typedef logic [7:0] dprs_byte_t;
endpackage : dprs_pkg

// ===== verilog/dprs_top.sv
// Debug port register select: two-wire link front end on the host clock and
// the target registers on the system clock, joined by a toggle handshake.
// Assumes the host holds the data line high when idle and stops its clock
// between frames; the core supplies a halt level on the system clock.
`timescale 1ns/1ps
`include "dprs_defines.svh"
module dprs_top #(
  parameter dprs_pkg::dprs_byte_t DEVICE_ID   = 8'h5a, // Arbitrary value
  parameter dprs_pkg::dprs_byte_t REVISION_ID = 8'h01  // Arbitrary value
) (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire logic                 halt_req,
  input  wire logic                 flash_dat_load,
  input  wire dprs_pkg::dprs_byte_t flash_dat_in,
  input  wire logic                 debug_port_clock,
  input  wire logic                 debug_port_data_in,
  output logic                      debug_port_data_out,
  output logic                      debug_port_data_oe_n,
  output logic                      periph_stall,
  output logic                      rst_pin_borrow,
  output logic                      gpio_pin_borrow,
  output dprs_pkg::dprs_byte_t      flash_program_control,
  output dprs_pkg::dprs_byte_t      flash_program_data,
  output logic                      flash_ctl_wr_pulse,
  output logic                      flash_dat_wr_pulse
);
  import dprs_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // System clock domain: registers
  //////////////////////////////////////////////////////////////////////////
  logic             stall_reg;
  logic             borrow_reg;
  dprs_byte_t       target_register_select_reg;
  dprs_byte_t       flash_ctl_reg;
  dprs_byte_t       flash_dat_reg;
  dprs_byte_t       rdata_reg;
  logic             ack_tog_reg;
  logic             ctl_wr_reg;
  logic             dat_wr_reg;
  logic             req_s1_reg;
  logic             req_s2_reg;
  logic             req_d_reg;

  // Link clock domain
  dprs_link_state_t state_reg;
  dprs_link_state_t state_next;
  logic [2:0]       cnt_reg;
  logic [2:0]       cnt_next;
  dprs_cmd_t        cmd_reg;
  dprs_byte_t       wdat_reg;
  dprs_byte_t       shift_reg;
  logic             req_tog_reg;
  logic             ack_s1_reg;
  logic             ack_s2_reg;
  logic             ack_d_reg;
  logic             en_s1_reg;
  logic             en_s2_reg;
  logic             lrst_s1_reg;
  logic             lrst_s2_reg;
  logic             dout_reg;
  logic             dout_next;
  logic             oe_n_reg;

  //////////////////////////////////////////////////////////////////////////
  // System domain decode
  //////////////////////////////////////////////////////////////////////////
  wire        exec      = req_s2_reg ^ req_d_reg;
  wire        cmd_awr   = (cmd_reg == `DPRS_CMD_ADDR_WR);
  wire        cmd_ard   = (cmd_reg == `DPRS_CMD_ADDR_RD);
  wire        cmd_dwr   = (cmd_reg == `DPRS_CMD_DATA_WR);
  wire        cmd_drd   = (cmd_reg == `DPRS_CMD_DATA_RD);
  wire        sel_dev   = (target_register_select_reg == `DPRS_ADDR_DEVICE_ID);
  wire        sel_rev   = (target_register_select_reg == `DPRS_ADDR_REVISION_ID);
  wire        sel_ctl   = (target_register_select_reg == `DPRS_ADDR_FLASH_CTL);
  wire        sel_dat   = (target_register_select_reg == `DPRS_ADDR_FLASH_DAT);
  wire        sel_wr    = exec && cmd_awr;
  wire        ctl_wr    = exec && cmd_dwr && sel_ctl;
  wire        dat_wr    = exec && cmd_dwr && sel_dat;
  wire        listed    = sel_dev || sel_rev || sel_ctl || sel_dat;
  // Unlisted selects read as zero and writes fall through untouched
  wire dprs_byte_t rd_mux = sel_dev ? DEVICE_ID :
                            sel_rev ? REVISION_ID :
                            sel_ctl ? flash_ctl_reg :
                            sel_dat ? flash_dat_reg :
                                      `DPRS_UNLISTED_READ;
  wire dprs_byte_t rdata_next = (exec && cmd_ard) ? target_register_select_reg :
                                (exec && cmd_drd) ? rd_mux : rdata_reg;
  wire dprs_byte_t sel_next   = sel_wr ? wdat_reg : target_register_select_reg;
  wire dprs_byte_t ctl_next   = ctl_wr ? wdat_reg : flash_ctl_reg;
  // A link write wins over a flash-side load in the same cycle
  wire dprs_byte_t dat_next   = dat_wr ? wdat_reg :
                                flash_dat_load ? flash_dat_in : flash_dat_reg;

  //////////////////////////////////////////////////////////////////////////
  // System domain flops
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stall_reg                  <= 1'b0;
      borrow_reg                 <= 1'b0;
      target_register_select_reg <= `DPRS_SEL_RESET;
      flash_ctl_reg              <= `DPRS_FLASH_CTL_RESET;
      flash_dat_reg              <= `DPRS_FLASH_DAT_RESET;
      rdata_reg                  <= `DPRS_RDATA_RESET;
      ack_tog_reg                <= 1'b0;
      ctl_wr_reg                 <= 1'b0;
      dat_wr_reg                 <= 1'b0;
      req_s1_reg                 <= 1'b0;
      req_s2_reg                 <= 1'b0;
      req_d_reg                  <= 1'b0;
    end else begin
      stall_reg                  <= halt_req;
      // Pins are borrowed one cycle after the stall takes hold and returned
      // at once on leaving halt, so user logic never sees both drivers
      borrow_reg                 <= halt_req && stall_reg;
      target_register_select_reg <= sel_next;
      flash_ctl_reg              <= ctl_next;
      flash_dat_reg              <= dat_next;
      rdata_reg                  <= rdata_next;
      ack_tog_reg                <= ack_tog_reg ^ exec;
      ctl_wr_reg                 <= ctl_wr;
      dat_wr_reg                 <= dat_wr;
      req_s1_reg                 <= req_tog_reg;
      req_s2_reg                 <= req_s1_reg;
      req_d_reg                  <= req_s2_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Link domain: synchronisers
  //////////////////////////////////////////////////////////////////////////
  // Reset reaches the link side only while its clock runs; a frame cut short
  // by reset is finished by the enable dropping two link edges after the borrow clears
  always_ff @(posedge debug_port_clock) begin
    lrst_s1_reg <= srst;
    lrst_s2_reg <= lrst_s1_reg;
  end

  wire ack_edge  = ack_s2_reg ^ ack_d_reg;
  wire din       = debug_port_data_in;
  wire dprs_cmd_t cmd_shift = {din, cmd_reg[1]};
  wire cmd_read  = cmd_reg[`DPRS_CMD_RD_BIT];
  wire req_fire  = (state_next == DPRS_LS_WAIT) && (state_reg != DPRS_LS_WAIT);
  wire drive_next = (state_next == DPRS_LS_WAIT) || (state_next == DPRS_LS_READY) ||
                    (state_next == DPRS_LS_SEND);

  //////////////////////////////////////////////////////////////////////////
  // Link state machine
  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      DPRS_LS_IDLE: begin
        if (!din) begin
          state_next = DPRS_LS_CMD;
          cnt_next   = 3'h0;
        end
      end
      DPRS_LS_CMD: begin
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == `DPRS_CMD_LAST) begin
          cnt_next   = 3'h0;
          state_next = cmd_shift[`DPRS_CMD_RD_BIT] ? DPRS_LS_WAIT : DPRS_LS_DATA;
        end
      end
      DPRS_LS_DATA: begin
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == `DPRS_BYTE_LAST) begin
          state_next = DPRS_LS_WAIT;
        end
      end
      DPRS_LS_WAIT: begin
        if (ack_edge) begin
          state_next = DPRS_LS_READY;
        end
      end
      DPRS_LS_READY: begin
        cnt_next   = 3'h0;
        state_next = cmd_read ? DPRS_LS_SEND : DPRS_LS_IDLE;
      end
      DPRS_LS_SEND: begin
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == `DPRS_BYTE_LAST) begin
          state_next = DPRS_LS_IDLE;
        end
      end
    endcase
    // Outside halt the pins belong to the user, so the port stays quiet
    if (!en_s2_reg) begin
      state_next = DPRS_LS_IDLE;
    end
  end

  always_comb begin
    unique case (state_next)
      DPRS_LS_WAIT:  dout_next = 1'b0;
      DPRS_LS_READY: dout_next = 1'b1;
      DPRS_LS_SEND:  dout_next = (state_reg == DPRS_LS_READY) ? rdata_reg[0] : shift_reg[0];
      default:       dout_next = 1'b1;
    endcase
  end

  // Read data is held steady by the handshake while it is sampled here
  wire dprs_byte_t shift_next = (state_reg == DPRS_LS_READY) ? {1'b0, rdata_reg[7:1]} :
                                {1'b0, shift_reg[7:1]};

  always_ff @(posedge debug_port_clock) begin
    if (lrst_s2_reg) begin
      state_reg   <= DPRS_LS_IDLE;
      cnt_reg     <= 3'h0;
      cmd_reg     <= `DPRS_CMD_ADDR_WR;
      wdat_reg    <= 8'h00;
      shift_reg   <= 8'h00;
      req_tog_reg <= 1'b0;
      ack_s1_reg  <= 1'b0;
      ack_s2_reg  <= 1'b0;
      ack_d_reg   <= 1'b0;
      en_s1_reg   <= 1'b0;
      en_s2_reg   <= 1'b0;
      dout_reg    <= 1'b1;
      oe_n_reg    <= 1'b1;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      if (state_reg == DPRS_LS_CMD) begin
        cmd_reg   <= cmd_shift;
      end
      if (state_reg == DPRS_LS_DATA) begin
        wdat_reg  <= {din, wdat_reg[7:1]};
      end
      shift_reg   <= shift_next;
      req_tog_reg <= req_tog_reg ^ req_fire;
      ack_s1_reg  <= ack_tog_reg;
      ack_s2_reg  <= ack_s1_reg;
      ack_d_reg   <= ack_s2_reg;
      en_s1_reg   <= borrow_reg;
      en_s2_reg   <= en_s1_reg;
      dout_reg    <= dout_next;
      oe_n_reg    <= !drive_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  //////////////////////////////////////////////////////////////////////////
  assign debug_port_data_out   = dout_reg;
  assign debug_port_data_oe_n  = oe_n_reg;
  assign periph_stall          = stall_reg;
  assign rst_pin_borrow        = borrow_reg;
  assign gpio_pin_borrow       = borrow_reg;
  assign flash_program_control = flash_ctl_reg;
  assign flash_program_data    = flash_dat_reg;
  assign flash_ctl_wr_pulse    = ctl_wr_reg;
  assign flash_dat_wr_pulse    = dat_wr_reg;

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  //////////////////////////////////////////////////////////////////////////
  a_select_write: assert property (@(posedge sys_clk) disable iff (srst)
    exec && cmd_awr |=> target_register_select_reg == $past(wdat_reg))
    else $error("select register missed a link write");
  a_devid_read: assert property (@(posedge sys_clk) disable iff (srst)
    exec && cmd_drd && sel_dev |=> rdata_reg == DEVICE_ID ##1 ack_tog_reg == $past(ack_tog_reg))
    else $error("device identifier not returned");
  a_revision_identifier_read: assert property (@(posedge sys_clk) disable iff (srst)
    exec && cmd_drd && sel_rev |=> rdata_reg == REVISION_ID)
    else $error("revision identifier not returned");
  a_ctl_access: assert property (@(posedge sys_clk) disable iff (srst)
    exec && cmd_dwr && sel_ctl |=> flash_ctl_reg == $past(wdat_reg) && flash_ctl_wr_pulse)
    else $error("flash control write lost");
  a_dat_access: assert property (@(posedge sys_clk) disable iff (srst)
    exec && cmd_drd && sel_dat |=> rdata_reg == $past(flash_dat_reg))
    else $error("flash data read wrong");
  a_halt_stall: assert property (@(posedge sys_clk) disable iff (srst)
    halt_req ##1 halt_req |=> periph_stall && rst_pin_borrow)
    else $error("halt did not stall and borrow");
  a_pin_release: assert property (@(posedge sys_clk) disable iff (srst)
    !halt_req |=> !rst_pin_borrow && !gpio_pin_borrow)
    else $error("pins kept after halt ended");
  a_select_hold: assert property (@(posedge sys_clk) disable iff (srst)
    !(exec && cmd_awr) |=> $stable(target_register_select_reg))
    else $error("select changed without a write");
  a_unlisted_nop: assert property (@(posedge sys_clk) disable iff (srst)
    exec && cmd_dwr && !listed && !flash_dat_load |=> $stable(flash_ctl_reg) && $stable(flash_dat_reg))
    else $error("unlisted write had an effect");
  a_ready_bit: assert property (@(posedge debug_port_clock) disable iff (lrst_s2_reg)
    state_reg == DPRS_LS_WAIT && ack_edge && en_s2_reg |=> !debug_port_data_oe_n && debug_port_data_out)
    else $error("ready bit not driven after acknowledge");

  c_addr_write: cover property (@(posedge sys_clk) disable iff (srst) exec && cmd_awr);
  c_devid_read: cover property (@(posedge sys_clk) disable iff (srst) exec && cmd_drd && sel_dev);
  c_dat_write:  cover property (@(posedge sys_clk) disable iff (srst) dat_wr);
  c_send_done:  cover property (@(posedge debug_port_clock) disable iff (lrst_s2_reg)
    state_reg == DPRS_LS_SEND ##1 state_reg == DPRS_LS_IDLE);

endmodule : dprs_top

// ===== verification/dprs_host_model.sv
// Host adapter model: makes the link clock in frames and when the bench asks for idle clocks, and drives
// or releases the data line. Assumes a pull-up on the data line.
`timescale 1ns/1ps
module dprs_host_model (
  output logic      debug_port_clock,
  output logic      debug_port_data_in,
  input  wire logic debug_port_data_out,
  input  wire logic debug_port_data_oe_n
);
  logic host_en;
  logic host_val;

  initial begin
    debug_port_clock = 1'b0;
    host_en          = 1'b0;
    host_val         = 1'b1;
  end

  // Resolved wire level; the pull-up shows when nobody drives
  assign debug_port_data_in = !debug_port_data_oe_n ? debug_port_data_out : (host_en ? host_val : 1'b1);

  ////////////////////////////////////////////////////////////////////////
  // One link period of 32 ns; the clock idles low between frames
  task automatic run_clocks(input int n);
    repeat (n) begin
      #16 debug_port_clock = 1'b1;
      #16 debug_port_clock = 1'b0;
    end
  endtask : run_clocks

  // Data changes while the clock is low; the line is freed after the last bit
  task automatic send_bit(input logic b, input logic last);
    host_en  = 1'b1;
    host_val = b;
    #16 debug_port_clock = 1'b1;
    #16 debug_port_clock = 1'b0;
    // Freeing on the sampling edge would race the device's capture of the bit
    if (last) begin
      host_en = 1'b0;
    end
  endtask : send_bit

  // Each target register is reached through a framed command on the link; flash data can also be loaded from the flash side
  task automatic frame(input logic [1:0] cmd, input logic [7:0] wd, output logic [7:0] rd, output logic ok);
    int n;
    rd = 8'h00;
    send_bit(1'b0, 1'b0);
    send_bit(cmd[0], 1'b0);
    send_bit(cmd[1], cmd[0]);
    if (!cmd[0]) begin
      for (int i = 0; i < 8; i++) begin
        send_bit(wd[i], i == 7);
      end
    end
    // Keep clocking through busy, bounded so a hang cannot stall the run
    n = 0;
    do begin
      run_clocks(1);
      n++;
    end while (debug_port_data_in !== 1'b1 && n < 60);
    ok = (n < 60);
    if (cmd[0]) begin
      for (int i = 0; i < 8; i++) begin
        run_clocks(1);
        rd[i] = debug_port_data_in;
      end
    end
    run_clocks(1);
    ok = ok && (debug_port_data_oe_n === 1'b1);
  endtask : frame
endmodule : dprs_host_model

// ===== verification/debug_port_register_select_tb.sv
// Self-checking bench for the debug port register select block.
// Assumes the host model on the link and a core halt level from the bench.
`timescale 1ns/1ps
module debug_port_register_select_tb;
  import dprs_pkg::*;
  `include "dprs_defines.svh"
  localparam dprs_byte_t DEV_ID = 8'h3c; // Arbitrary value
  localparam dprs_byte_t REV_ID = 8'h07; // Arbitrary value
  logic       sys_clk, srst, halt_req, flash_dat_load, ok;
  logic       debug_port_clock, debug_port_data_in, debug_port_data_out, debug_port_data_oe_n;
  logic       periph_stall, rst_pin_borrow, gpio_pin_borrow, flash_ctl_wr_pulse, flash_dat_wr_pulse;
  dprs_byte_t flash_dat_in, flash_program_control, flash_program_data, rd, exp_sel, exp_ctl, exp_dat;
  int         fails, check_count, cycles, ctl_pulses, dat_pulses, exp_cp, exp_dp;
  dprs_byte_t addrs [6] = '{8'h00, 8'h01, 8'h02, 8'hb4, 8'h03, 8'hff};

  dprs_top #(.DEVICE_ID(DEV_ID), .REVISION_ID(REV_ID)) u_dut (
    .sys_clk(sys_clk), .srst(srst), .halt_req(halt_req), .flash_dat_load(flash_dat_load),
    .flash_dat_in(flash_dat_in), .debug_port_clock(debug_port_clock),
    .debug_port_data_in(debug_port_data_in), .debug_port_data_out(debug_port_data_out),
    .debug_port_data_oe_n(debug_port_data_oe_n), .periph_stall(periph_stall),
    .rst_pin_borrow(rst_pin_borrow), .gpio_pin_borrow(gpio_pin_borrow),
    .flash_program_control(flash_program_control), .flash_program_data(flash_program_data),
    .flash_ctl_wr_pulse(flash_ctl_wr_pulse), .flash_dat_wr_pulse(flash_dat_wr_pulse));

  dprs_host_model u_host (
    .debug_port_clock(debug_port_clock), .debug_port_data_in(debug_port_data_in),
    .debug_port_data_out(debug_port_data_out), .debug_port_data_oe_n(debug_port_data_oe_n));

  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  // Pulse counting and the hang limit; the run needs about a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (flash_ctl_wr_pulse === 1'b1) ctl_pulses++;
    if (flash_dat_wr_pulse === 1'b1) dat_pulses++;
    if (cycles == 30000) begin
      fails++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic dprs_byte_t exp_read(input dprs_byte_t sel);
    case (sel)
      `DPRS_ADDR_DEVICE_ID:   return DEV_ID;
      `DPRS_ADDR_REVISION_ID: return REV_ID;
      `DPRS_ADDR_FLASH_CTL:   return exp_ctl;
      `DPRS_ADDR_FLASH_DAT:   return exp_dat;
      default:                return `DPRS_UNLISTED_READ;
    endcase
  endfunction : exp_read

  task automatic check(input string name, input dprs_byte_t seen, input dprs_byte_t exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic access(input dprs_cmd_t cmd, input dprs_byte_t wd);
    u_host.frame(cmd, wd, rd, ok);
    check("frame handshake", {7'h00, ok}, 8'h01);
  endtask : access

  task automatic sel_wr(input dprs_byte_t a);
    access(`DPRS_CMD_ADDR_WR, a);
    exp_sel = a;
    access(`DPRS_CMD_ADDR_RD, 8'h00);
    check("select readback", rd, exp_sel);
  endtask : sel_wr

  task automatic dat_wr(input dprs_byte_t d);
    access(`DPRS_CMD_DATA_WR, d);
    if (exp_sel == `DPRS_ADDR_FLASH_CTL) begin
      exp_ctl = d;
      exp_cp++;
    end else if (exp_sel == `DPRS_ADDR_FLASH_DAT) begin
      exp_dat = d;
      exp_dp++;
    end
    check("flash control", flash_program_control, exp_ctl);
    check("flash data", flash_program_data, exp_dat);
    check("control pulses", 8'(ctl_pulses), 8'(exp_cp));
    check("data pulses", 8'(dat_pulses), 8'(exp_dp));
  endtask : dat_wr

  task automatic dat_rd();
    access(`DPRS_CMD_DATA_RD, 8'h00);
    check("data read", rd, exp_read(exp_sel));
  endtask : dat_rd

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    halt_req = 1'b0;
    flash_dat_load = 1'b0;
    flash_dat_in = 8'h00;
    fails = 0;
    check_count = 0;
    cycles = 0;
    ctl_pulses = 0;
    dat_pulses = 0;
    exp_cp = 0;
    exp_dp = 0;
    exp_sel = `DPRS_SEL_RESET;
    exp_ctl = `DPRS_FLASH_CTL_RESET;
    exp_dat = `DPRS_FLASH_DAT_RESET;
    void'($urandom(32'h63b2));
    // Link reset needs the link clock running while srst is high
    fork
      u_host.run_clocks(6);
      repeat (5) @(negedge sys_clk);
    join
    srst = 1'b0;
    @(negedge sys_clk);
    check("reset outputs", {3'h0, debug_port_data_oe_n, periph_stall, rst_pin_borrow, gpio_pin_borrow, 1'b0},
          8'h10);
    check("reset control", flash_program_control, exp_ctl);
    $display("test reset done");
    // A start while the core runs must be ignored; first let the link leave reset
    u_host.run_clocks(3);
    u_host.send_bit(1'b0, 1'b0);
    u_host.send_bit(1'b1, 1'b0);
    u_host.send_bit(1'b1, 1'b1);
    u_host.run_clocks(8);
    check("refused drive", {7'h00, debug_port_data_oe_n}, 8'h01);
    @(negedge sys_clk) halt_req = 1'b1;
    @(negedge sys_clk);
    check("stall then borrow", {6'h00, periph_stall, rst_pin_borrow}, 8'h02);
    @(negedge sys_clk);
    check("pins borrowed", {6'h00, rst_pin_borrow, gpio_pin_borrow}, 8'h03);
    u_host.run_clocks(4);
    $display("test halt done");
    foreach (addrs[i]) begin
      sel_wr(addrs[i]);
      dat_wr(8'($urandom));
      dat_rd();
      dat_rd();
    end
    $display("test listed addresses done");
    sel_wr(`DPRS_ADDR_FLASH_DAT);
    @(negedge sys_clk) flash_dat_in = 8'($urandom);
    flash_dat_load = 1'b1;
    exp_dat = flash_dat_in;
    @(negedge sys_clk) flash_dat_load = 1'b0;
    dat_rd();
    $display("test flash load done");
    repeat (24) begin
      case ($urandom % 3)
        0:       sel_wr(($urandom % 2) ? addrs[$urandom % 6] : 8'($urandom));
        1:       dat_wr(8'($urandom));
        default: dat_rd();
      endcase
    end
    $display("test random done");
    @(negedge sys_clk) halt_req = 1'b0;
    @(negedge sys_clk);
    check("halt release", {5'h00, periph_stall, rst_pin_borrow, gpio_pin_borrow}, 8'h00);
    $display("test release done");
    tally_and_finish();
  end
endmodule : debug_port_register_select_tb
